// ### tios_pkg.sv
/*
 * Constants for the timer I/O function select block: register offsets,
 * field positions, reset values and field codes.
 * Assumes a 32-bit APB slave with one aligned word per register.
 */
package tios_pkg;

    // Register byte offsets
    localparam logic [7:0] CH0_IO_SELECT_HIGH_OFFSET = 8'h00;
    localparam logic [7:0] CH0_IO_SELECT_LOW_OFFSET = 8'h04;
    localparam logic [7:0] CH1_IO_SELECT_OFFSET = 8'h08;
    localparam logic [7:0] CH2_IO_SELECT_OFFSET = 8'h0C;
    localparam logic [7:0] PIN_STATUS_OFFSET = 8'h10;

    // Register geometry
    localparam int REG_WIDTH = 8;
    localparam int NUM_SELECT_REGS = 4;
    localparam logic [7:0] IO_SELECT_RESET = 8'h00;

    // Field layout inside an I/O select register
    localparam int FIELD_WIDTH = 4;
    localparam int FIELD_LOW_POS = 0;
    localparam int FIELD_HIGH_POS = 4;
    localparam int FIELD_TOP_BIT = 3;
    localparam int FIELD_LEVEL_BIT = 2;

    // Function codes of the low two bits
    localparam logic [1:0] OUT_DISABLED = 2'h0;
    localparam logic [1:0] OUT_LOW = 2'h1;
    localparam logic [1:0] OUT_HIGH = 2'h2;
    localparam logic [1:0] OUT_TOGGLE = 2'h3;

    // Decoded fields: 0 ch0 A, 1 ch0 C, 2 ch1 A, 3 ch1 B, 4 ch2 A, 5 ch2 B
    localparam int NUM_FIELDS = 6;
    localparam int FIELD_REG [NUM_FIELDS] = '{0, 1, 2, 2, 3, 3};
    localparam int FIELD_POS [NUM_FIELDS] = '{0, 0, 0, 4, 0, 4};
    localparam int FIELD_CHANNEL [NUM_FIELDS] = '{0, 0, 1, 1, 2, 2};
    localparam bit FIELD_BIT2_IGNORED [NUM_FIELDS] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    localparam int BUFFERED_FIELD = 1;

    localparam int NUM_CHANNELS = 3;
    localparam int COUNTER_WIDTH = 16;

endpackage : tios_pkg

// ### tios_io_field.sv
/*
 * One compare/capture function unit: decodes a 4-bit field, drives the
 * channel pin on compare match and raises capture strobes on pin edges.
 * Assumes the pin input is asynchronous and the match strobe is on pclk.
 */
`timescale 1ns/1ps
`default_nettype none

module tios_io_field #(
    parameter int CW = 16,
    parameter bit BIT2_IGNORED = 1'b0
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // Control
    input wire logic [3:0] field,
    input wire logic field_valid,
    input wire logic counter_run,
    input wire logic compare_match,
    input wire logic [CW-1:0] counter_value,
    // Pin
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    // Capture
    output logic capture_strobe,
    output logic [CW-1:0] capture_value
);

    logic sync1, sync2, pin_prev;
    logic next_pin_out, next_pin_oe, next_capture_strobe;
    logic [CW-1:0] next_capture_value;
    logic is_out, is_cap, rise, fall, cap_hit;

    always_comb begin
        is_out = field_valid && !field[3] && (field[1:0] != tios_pkg::OUT_DISABLED);
        is_cap = field_valid && field[3] && (BIT2_IGNORED || !field[2]);
        rise = sync2 && !pin_prev;
        fall = !sync2 && pin_prev;
        cap_hit = 1'b0;
        if (is_cap) begin
            if (field[1]) begin
                cap_hit = rise || fall;
            end else if (field[0]) begin
                cap_hit = fall;
            end else begin
                cap_hit = rise;
            end
        end
        next_pin_oe = is_out;
        next_pin_out = pin_out;
        if (!is_out) begin
            next_pin_out = 1'b0;
        end else if (!counter_run) begin
            next_pin_out = field[2];
        end else if (compare_match) begin
            unique case (field[1:0])
                tios_pkg::OUT_LOW: next_pin_out = 1'b0;
                tios_pkg::OUT_HIGH: next_pin_out = 1'b1;
                tios_pkg::OUT_TOGGLE: next_pin_out = !pin_out;
                tios_pkg::OUT_DISABLED: next_pin_out = 1'b0;
            endcase
        end
        next_capture_strobe = cap_hit;
        next_capture_value = cap_hit ? counter_value : capture_value;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            pin_prev <= 1'b0;
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
            capture_strobe <= 1'b0;
            capture_value <= '0;
        end else if (clk_en) begin
            sync1 <= pin_in;
            sync2 <= sync1;
            pin_prev <= sync2;
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
            capture_strobe <= next_capture_strobe;
            capture_value <= next_capture_value;
        end
    end

endmodule : tios_io_field

`default_nettype wire

// ### tios_top.sv
/*
 * Timer I/O function select: four I/O select registers on APB and six
 * compare/capture function units driving and sampling channel pins.
 * Assumes the counter, mode register and run bits live outside and
 * arrive as plain pclk-domain inputs.
 */
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - The low nibble of each channel's select register picks the function of register A.
// - In channel 0 the low nibble of the second select register picks the function of register C.
// - Output code with low bits 01 drives the pin low on match, bit 2 giving the initial level.
// - Output code with low bits 10 drives the pin high on match, bit 2 giving the initial level.
// - Low bits 11 toggle the pin on each match and low bits 00 disable the output, 0000 at reset.
// - Capture code 1x00 latches the counter on a rising edge of the field's own pin.
// - Capture code with low bits 01 latches the counter on a falling edge of the pin.
// - Capture with bit 1 set latches on both edges, and channel 2 also ignores bit 2.
// - With buffer enable A set, the register C field is ignored and makes no capture or output.
// - In channels 0 and 1 a capture code with bit 2 set is a prohibited setting.
// - The initial level of an output field is applied only while its counter is stopped.
// - Reset clears every I/O select register to zero.
module tios_top #(
    parameter int CW = tios_pkg::COUNTER_WIDTH
) (
    // Clock, reset and enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer side
    input wire logic [tios_pkg::NUM_CHANNELS-1:0] counter_run_bit,
    input wire logic buffer_enable_a,
    input wire logic [tios_pkg::NUM_CHANNELS-1:0][CW-1:0] counter_value,
    input wire logic [tios_pkg::NUM_FIELDS-1:0] compare_match,
    // Channel pins
    input wire logic [tios_pkg::NUM_FIELDS-1:0] field_pin_in,
    output logic [tios_pkg::NUM_FIELDS-1:0] field_pin_out,
    output logic [tios_pkg::NUM_FIELDS-1:0] field_pin_oe,
    // Capture
    output logic [tios_pkg::NUM_FIELDS-1:0] capture_strobe,
    output logic [tios_pkg::NUM_FIELDS-1:0][CW-1:0] capture_value
);

    logic [tios_pkg::REG_WIDTH-1:0] io_select_register [tios_pkg::NUM_SELECT_REGS];
    logic [tios_pkg::REG_WIDTH-1:0] next_io_select [tios_pkg::NUM_SELECT_REGS];
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic setup_phase, access_done;

    // APB decode, register writes and registered read data
    always_comb begin
        setup_phase = psel && !penable;
        access_done = psel && penable && pready;
        next_pready = setup_phase;
        next_pslverr = 1'b0;
        next_prdata = prdata;
        for (int i = 0; i < tios_pkg::NUM_SELECT_REGS; i++) begin
            next_io_select[i] = io_select_register[i];
        end
        if (setup_phase) begin
            next_prdata = 32'h0000_0000;
            unique case (paddr)
                tios_pkg::CH0_IO_SELECT_HIGH_OFFSET: next_prdata[7:0] = io_select_register[0];
                tios_pkg::CH0_IO_SELECT_LOW_OFFSET: next_prdata[7:0] = io_select_register[1];
                tios_pkg::CH1_IO_SELECT_OFFSET: next_prdata[7:0] = io_select_register[2];
                tios_pkg::CH2_IO_SELECT_OFFSET: next_prdata[7:0] = io_select_register[3];
                tios_pkg::PIN_STATUS_OFFSET: begin
                    next_prdata[5:0] = field_pin_out;
                    next_prdata[13:8] = field_pin_oe;
                end
                default: next_pslverr = 1'b1;
            endcase
        end
        if (access_done && pwrite && !pslverr) begin
            unique case (paddr)
                tios_pkg::CH0_IO_SELECT_HIGH_OFFSET: next_io_select[0] = pwdata[7:0];
                tios_pkg::CH0_IO_SELECT_LOW_OFFSET: next_io_select[1] = pwdata[7:0];
                tios_pkg::CH1_IO_SELECT_OFFSET: next_io_select[2] = pwdata[7:0];
                tios_pkg::CH2_IO_SELECT_OFFSET: next_io_select[3] = pwdata[7:0];
                default: next_prdata = prdata;
            endcase
        end
        if (access_done) begin
            next_pslverr = 1'b0;
        end else if (!setup_phase) begin
            next_pslverr = pslverr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < tios_pkg::NUM_SELECT_REGS; i++) begin
                io_select_register[i] <= tios_pkg::IO_SELECT_RESET;
            end
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            for (int i = 0; i < tios_pkg::NUM_SELECT_REGS; i++) begin
                io_select_register[i] <= next_io_select[i];
            end
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // One function unit per decoded field
    for (genvar g = 0; g < tios_pkg::NUM_FIELDS; g++) begin : gen_field
        localparam int REG_IDX = tios_pkg::FIELD_REG[g];
        localparam int POS = tios_pkg::FIELD_POS[g];
        localparam int CH = tios_pkg::FIELD_CHANNEL[g];
        logic [3:0] field;
        logic field_valid;

        assign field = io_select_register[REG_IDX][POS +: tios_pkg::FIELD_WIDTH];
        assign field_valid = (g == tios_pkg::BUFFERED_FIELD) ? !buffer_enable_a : 1'b1;

        tios_io_field #(
            .CW(CW),
            .BIT2_IGNORED(tios_pkg::FIELD_BIT2_IGNORED[g])
        ) u_field (
            .pclk(pclk),
            .presetn(presetn),
            .clk_en(clk_en),
            .field(field),
            .field_valid(field_valid),
            .counter_run(counter_run_bit[CH]),
            .compare_match(compare_match[g]),
            .counter_value(counter_value[CH]),
            .pin_in(field_pin_in[g]),
            .pin_out(field_pin_out[g]),
            .pin_oe(field_pin_oe[g]),
            .capture_strobe(capture_strobe[g]),
            .capture_value(capture_value[g])
        );
    end

endmodule : tios_top

`default_nettype wire

// ### tios_props.sv
/* Checker for the timer I/O select top: mirrors the select registers
   from APB writes. Checks are held off while clk_en is low. */
`timescale 1ns/1ps
`default_nettype none
module tios_props (
    // APB side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Timer side and pins
    input wire logic [2:0] counter_run_bit,
    input wire logic buffer_enable_a,
    input wire logic [5:0] compare_match,
    input wire logic [5:0] field_pin_in,
    input wire logic [5:0] field_pin_out,
    input wire logic [5:0] field_pin_oe,
    input wire logic [5:0] capture_strobe
);
    logic [7:0] sh [4];
    wire wr_now = clk_en && psel && penable && pready && pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sh <= '{default: 8'h00};
        else if (wr_now && paddr < 8'h10 && paddr[1:0] == 2'h0) sh[paddr[3:2]] <= pwdata[7:0];
    end
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn || !clk_en);
    init_level_a: assert property (
        !sh[0][3] && sh[0][1:0] != 2'h0 && !counter_run_bit[0] && !wr_now
        |=> field_pin_oe[0] && field_pin_out[0] == $past(sh[0][2])) else $error("init level");
    match_low_a: assert property (
        !sh[2][3] && sh[2][1:0] == 2'h1 && counter_run_bit[1] && compare_match[2] && !wr_now
        |=> !field_pin_out[2]) else $error("match low");
    match_toggle_a: assert property (
        !sh[2][7] && sh[2][5:4] == 2'h3 && counter_run_bit[1] && compare_match[3] && !wr_now
        |=> field_pin_out[3] != $past(field_pin_out[3])) else $error("toggle");
    rise_cap_a: assert property (
        sh[2][3:0] == 4'h8 && $rose(field_pin_in[2]) |-> ##[1:5] capture_strobe[2])
        else $error("rise capture");
    fall_cap_a: assert property (
        sh[2][7:4] == 4'h9 && $fell(field_pin_in[3]) |-> ##[1:5] capture_strobe[3])
        else $error("fall capture");
    both_cap_a: assert property (
        sh[3][3] && sh[3][1] && $changed(field_pin_in[4]) |-> ##[1:5] capture_strobe[4])
        else $error("both capture");
    buffer_off_a: assert property (
        buffer_enable_a [*4] |-> !field_pin_oe[1] && !capture_strobe[1]) else $error("buffer");
    prohibited_code_a: assert property (
        (sh[0][3:2] == 2'h3) [*4] |-> !field_pin_oe[0] && !capture_strobe[0])
        else $error("prohibited");
endmodule : tios_props
bind tios_top tios_props props_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready),
    .counter_run_bit(counter_run_bit), .buffer_enable_a(buffer_enable_a),
    .compare_match(compare_match), .field_pin_in(field_pin_in),
    .field_pin_out(field_pin_out), .field_pin_oe(field_pin_oe),
    .capture_strobe(capture_strobe));
`default_nettype wire

// ### tios_pins.sv
/* Outside world at the channel capture pins.
   Assumes the bench sets wanted levels and a prompt or slow pace. */
`timescale 1ns/1ps
`default_nettype none
module tios_pins (
    // Clock and control
    input wire logic pclk,
    input wire logic slow,
    input wire logic [5:0] want,
    // Pins
    output logic [5:0] pin
);
    logic [5:0] lag;
    initial begin
        lag = 6'h00;
        pin = 6'h00;
    end
    always @(posedge pclk) begin
        lag <= want;
        pin <= slow ? lag : want;
    end
endmodule : tios_pins
`default_nettype wire

// ### testbench.sv
/* Bench for the timer I/O select top: APB tasks and scenarios.
   Assumes the checker is bound and the pin model drives the inputs. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic pclk = 1'h0, presetn = 1'h0, clk_en = 1'h1, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, buffer_enable_a = 1'h0, slow = 1'h0, pready, pslverr, rerr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [2:0] run = 3'h0;
    logic [2:0][15:0] cnt = '0;
    logic [5:0] match = 6'h00, want = 6'h00, pin_in, pout, poe, cs;
    logic [5:0][15:0] cv;
    int n_errors = 0, check_count = 0;
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) cnt <= {cnt[2] + 16'h0003, cnt[1] + 16'h0002, cnt[0] + 16'h0001};
    tios_top dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .counter_run_bit(run),
        .buffer_enable_a(buffer_enable_a), .counter_value(cnt), .compare_match(match),
        .field_pin_in(pin_in), .field_pin_out(pout), .field_pin_oe(poe),
        .capture_strobe(cs), .capture_value(cv));
    tios_pins pins_u (.pclk(pclk), .slow(slow), .want(want), .pin(pin_in));
    task finish_test;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'h1 && i < 20);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) begin
            n_errors++;
            finish_test();
        end
    endtask : apb
    task rst_zero;
        presetn <= 1'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        for (int a = 0; a < 5; a++) begin
            apb(1'h0, 8'(a * 4), 32'h0);
            chk(rdat, 32'h0);
        end
    endtask : rst_zero
    task pulse(input logic [5:0] m);
        match <= m;
        @(posedge pclk);
        match <= 6'h00;
        repeat (3) @(posedge pclk);
    endtask : pulse
    task pin(input int f, input logic lvl, input logic exp);
        logic seen;
        logic [15:0] e;
        seen = 1'h0;
        want[f] <= lvl;
        repeat (8) begin
            @(posedge pclk);
            e = cnt[f / 2] - 16'(f / 2 + 1);
            if (cs[f] === 1'h1) begin
                seen = 1'h1;
                chk(32'(cv[f]), 32'(e));
            end
        end
        chk(32'(seen), 32'(exp));
    endtask : pin
    initial begin
        rst_zero();
        for (int a = 0; a < 4; a++) begin
            apb(1'h1, 8'(a * 4), 32'hABCD0080 + 32'(a));
            apb(1'h0, 8'(a * 4), 32'h0);
            chk(rdat, 32'h80 + 32'(a));
        end
        apb(1'h0, 8'h14, 32'h0);
        chk(32'(rerr), 32'h1);
        rst_zero();
        for (int f = 0; f < 2; f++) begin
            for (int c = 0; c < 8; c++) begin
                apb(1'h1, 8'(f * 4), 32'(c));
                repeat (3) @(posedge pclk);
                apb(1'h0, 8'h10, 32'h0);
                chk(rdat, c % 4 == 0 ? 32'h0 : (32'h100 | 32'(c / 4)) << f);
            end
            apb(1'h1, 8'(f * 4), 32'h0);
        end
        apb(1'h1, 8'h08, 32'h25);
        repeat (3) @(posedge pclk);
        chk(32'(pout[3:2]), 32'h1);
        run <= 3'h7;
        pulse(6'h0C);
        chk(32'(pout[3:2]), 32'h2);
        apb(1'h1, 8'h08, 32'h35);
        repeat (3) @(posedge pclk);
        chk(32'(pout[3]), 32'h1);
        pulse(6'h08);
        chk(32'(pout[3]), 32'h0);
        clk_en <= 1'h0;
        pulse(6'h08);
        chk(32'(pout[3]), 32'h0);
        clk_en <= 1'h1;
        pulse(6'h08);
        chk(32'(pout[3]), 32'h1);
        apb(1'h1, 8'h00, 32'h0C);
        apb(1'h1, 8'h04, 32'h0A);
        apb(1'h1, 8'h08, 32'h98);
        apb(1'h1, 8'h0C, 32'hCE);
        buffer_enable_a <= 1'h1;
        apb(1'h0, 8'h10, 32'h0);
        chk(rdat, 32'h0);
        pin(2, 1'h1, 1'h1);
        pin(2, 1'h0, 1'h0);
        slow <= 1'h1;
        pin(3, 1'h1, 1'h0);
        pin(3, 1'h0, 1'h1);
        pin(4, 1'h1, 1'h1);
        pin(4, 1'h0, 1'h1);
        pin(5, 1'h1, 1'h1);
        pin(5, 1'h0, 1'h0);
        pin(0, 1'h1, 1'h0);
        pin(1, 1'h1, 1'h0);
        buffer_enable_a <= 1'h0;
        pin(1, 1'h0, 1'h1);
        rst_zero();
        finish_test();
    end
endmodule : testbench
`default_nettype wire
